// [rtl/ucb_params.svh]
// Register offsets, field positions and timing constants of the UART channel
`ifndef UCB_PARAMS_SVH
`define UCB_PARAMS_SVH
// Device register port offsets
`define UCB_A_DATA   3'h0
`define UCB_A_IER    3'h1
`define UCB_A_ISR    3'h2
`define UCB_A_FCR    3'h2
`define UCB_A_LCR    3'h3
`define UCB_A_MCR    3'h4
`define UCB_A_LSR    3'h5
`define UCB_A_ENHANCED_MODE_STATUS_REG   3'h6
`define UCB_A_EFR    3'h7
// Reset values
`define UCB_DLL_RST  8'h01
`define UCB_DLM_RST  8'h00
`define UCB_REG_RST  8'h00
// Field positions
`define UCB_MCR_PRE  7
`define UCB_MCR_RTS  1
`define UCB_ENHANCED_MODE_STATUS_REG_16X 7
`define UCB_FCR_EN   0
`define UCB_FCR_RXCLR 1
`define UCB_FCR_TXCLR 2
`define UCB_IER_RX   0
`define UCB_IER_TX   1
`define UCB_IER_RTS  6
`define UCB_EFR_ENH  4
`define UCB_EFR_ARTS 6
`define UCB_LCR_STB  2
`define UCB_LCR_PEN  3
`define UCB_LCR_EPS  4
`define UCB_LCR_DLAB 7
// FIFO geometry
`define UCB_DEPTH    64
`define UCB_PW       6
`define UCB_CAP_FIFO 7'h40
`define UCB_CAP_ONE  7'h01
// Oversampling and timeout counts
`define UCB_OS16     5'h10
`define UCB_OS8      5'h08
`define UCB_HALF16   5'h08
`define UCB_HALF8    5'h04
`define UCB_PRE4     2'h3
`define UCB_TO_EXTRA 8'h0c
// Interrupt status codes
`define UCB_ISR_NONE 8'h01
`define UCB_ISR_TX   8'h02
`define UCB_ISR_RX   8'h04
`define UCB_ISR_TO   8'h0c
`define UCB_ISR_RTS  8'h20
// Host APB register offsets and fields
`define UCB_H_CMD    12'h000
`define UCB_H_STAT   12'h004
`define UCB_H_WRBIT  11
`define UCB_H_BUSY   8
`define UCB_H_IRQ    9
`endif

// [rtl/ucb_pkg.sv]
// Types shared by both ends of the UART channel
package ucb_pkg;
    typedef enum logic [1:0] {UCB_RX_IDLE, UCB_RX_START, UCB_RX_BITS} ucb_rx_st_t;
    typedef enum logic [1:0] {UCB_H_IDLE, UCB_H_STROBE, UCB_H_CAPT} ucb_host_st_t;
    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } ucb_rxent_t;
endpackage

// [rtl/ucb_if.sv]
// Parallel byte register port between the host end and the UART end
`timescale 1ns/1ps
`default_nettype none
interface ucb_if;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       rd;
    logic       irq;
    modport dev  (input addr, wdata, wr, rd, output rdata, irq);
    modport host (output addr, wdata, wr, rd, input rdata, irq);
endinterface
`default_nettype wire

// [rtl/ucb_dev.sv]
// UART channel: baud generator, transmitter, receiver and auto RTS
//
// Design decisions made here: the register addresses and register access over the byte register port.
`timescale 1ns/1ps
`default_nettype none
`include "ucb_params.svh"
module ucb_dev (
    // Clock, reset, enable
    input  wire logic CORE_CLK,
    input  wire logic RST_N,
    input  wire logic CE,
    // Register port
    ucb_if.dev        BUS,
    // Serial side
    input  wire logic RX,
    output var  logic TX,
    output var  logic RTS_N
);
    import ucb_pkg::*;

    logic [7:0]  dll_q, dlm_q, ier_q, fcr_q, lcr_q, mcr_q, enhanced_mode_status_reg_q, efr_q;
    logic        dlab, fifo_on, os16, pen;
    logic [6:0]  cap;
    logic [3:0]  nbits;
    logic [7:0]  dmask;

    assign dlab    = lcr_q[`UCB_LCR_DLAB];
    assign fifo_on = fcr_q[`UCB_FCR_EN];
    assign os16    = enhanced_mode_status_reg_q[`UCB_ENHANCED_MODE_STATUS_REG_16X];
    assign pen     = lcr_q[`UCB_LCR_PEN];
    assign cap     = fifo_on ? `UCB_CAP_FIFO : `UCB_CAP_ONE;
    assign nbits   = {2'h0, lcr_q[1:0]} + 4'h5;
    assign dmask   = 8'hff >> (2'h3 - lcr_q[1:0]);

    function automatic logic par_of(input logic [7:0] d, input logic even);
        par_of = even ? ^d : ~^d;
    endfunction

    // Register writes
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dll_q  <= `UCB_DLL_RST;
            dlm_q  <= `UCB_DLM_RST;
            ier_q  <= `UCB_REG_RST;
            fcr_q  <= `UCB_REG_RST;
            lcr_q  <= `UCB_REG_RST;
            mcr_q  <= `UCB_REG_RST;
            enhanced_mode_status_reg_q <= `UCB_REG_RST;
            efr_q  <= `UCB_REG_RST;
        end else if (CE && BUS.wr) begin
            if (BUS.addr == `UCB_A_DATA && dlab) begin
                dll_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_IER && dlab) begin
                dlm_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_IER) begin
                ier_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_ISR) begin
                fcr_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_LCR) begin
                lcr_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_MCR) begin
                mcr_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_ENHANCED_MODE_STATUS_REG) begin
                enhanced_mode_status_reg_q <= BUS.wdata;
            end else if (BUS.addr == `UCB_A_EFR) begin
                efr_q <= BUS.wdata;
            end
        end
    end

    // Prescaler and baud generator; ticks are enables, no derived clocks
    logic [1:0]  pre_q;
    logic [15:0] brg_q, div;
    logic        pre_tick, os_tick;
    logic [4:0]  bit_len, half_len;

    assign div      = {dlm_q, dll_q};
    assign pre_tick = !mcr_q[`UCB_MCR_PRE] || (pre_q == `UCB_PRE4);
    assign os_tick  = pre_tick && (brg_q >= div - 16'h1);
    assign bit_len  = os16 ? `UCB_OS16 : `UCB_OS8;
    assign half_len = os16 ? `UCB_HALF16 : `UCB_HALF8;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pre_q <= 2'h0;
            brg_q <= 16'h0;
        end else if (CE) begin
            pre_q <= pre_q + 2'h1;
            if (pre_tick) begin
                brg_q <= os_tick ? 16'h0 : brg_q + 16'h1;
            end
        end
    end

    // Transmit fifo; depth one outside fifo mode
    logic [7:0]          txm [0:`UCB_DEPTH-1];
    logic [`UCB_PW-1:0]  twp_q, trp_q;
    logic [6:0]          tcnt_q;
    logic                tx_busy_q, tx_push, tx_pop, tx_clr;
    logic [11:0]         tx_sh_q, fr;
    logic [3:0]          tx_left_q, tx_len;
    logic [4:0]          tx_os_q;
    logic [7:0]          tx_d;

    assign tx_clr  = BUS.wr && BUS.addr == `UCB_A_ISR && BUS.wdata[`UCB_FCR_TXCLR];
    assign tx_push = BUS.wr && BUS.addr == `UCB_A_DATA && !dlab && tcnt_q < cap;
    // Load only on a tick, else the start bit comes up short by a partial tick
    assign tx_pop  = !tx_busy_q && tcnt_q != 7'h0 && os_tick;
    assign tx_d    = txm[trp_q] & dmask;
    assign tx_len  = 4'h2 + nbits + {3'h0, pen} + {3'h0, lcr_q[`UCB_LCR_STB]};

    always_comb begin
        fr    = 12'hfff;
        fr[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(nbits)) fr[i+1] = tx_d[i];
        end
        if (pen) fr[nbits+4'h1] = par_of(tx_d, lcr_q[`UCB_LCR_EPS]);
    end

    always_ff @(posedge CORE_CLK) begin
        if (CE && tx_push) txm[twp_q] <= BUS.wdata;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            twp_q  <= '0;
            trp_q  <= '0;
            tcnt_q <= 7'h0;
        end else if (CE) begin
            if (tx_clr) begin
                twp_q  <= '0;
                trp_q  <= '0;
                tcnt_q <= 7'h0;
            end else begin
                if (tx_push) twp_q <= twp_q + 1'b1;
                if (tx_pop) trp_q <= trp_q + 1'b1;
                tcnt_q <= tcnt_q + {6'h0, tx_push} - {6'h0, tx_pop};
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 12'hfff;
            tx_left_q <= 4'h0;
            tx_os_q   <= 5'h0;
            TX        <= 1'b1;
        end else if (CE) begin
            if (tx_pop) begin
                tx_busy_q <= 1'b1;
                tx_sh_q   <= fr;
                tx_left_q <= tx_len;
                tx_os_q   <= 5'h0;
                TX        <= 1'b0;
            end else if (tx_busy_q && os_tick) begin
                tx_os_q <= tx_os_q + 5'h1;
                if (tx_os_q == bit_len - 5'h1) begin
                    tx_os_q   <= 5'h0;
                    tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                    tx_left_q <= tx_left_q - 4'h1;
                    TX        <= (tx_left_q == 4'h1) ? 1'b1 : tx_sh_q[1];
                    if (tx_left_q == 4'h1) tx_busy_q <= 1'b0;
                end
            end
        end
    end

    // Receiver: line passes two flops before use
    logic        rx_m_q, rx_s_q, rx_p_q;
    ucb_rx_st_t  rx_st_q;
    logic [4:0]  rx_os_q;
    logic [3:0]  rx_k_q, rx_tot;
    logic [10:0] rx_sh_q, rx_full, rx_al;
    logic        rx_done;
    ucb_rxent_t  rx_ent;

    assign rx_tot  = nbits + {3'h0, pen} + 4'h1;
    assign rx_full = {rx_s_q, rx_sh_q[10:1]};
    assign rx_al   = rx_full >> (4'hb - rx_tot);
    assign rx_done = rx_st_q == UCB_RX_BITS && os_tick && rx_os_q == bit_len - 5'h1
                     && rx_k_q == rx_tot - 4'h1;

    always_comb begin
        rx_ent.data = rx_al[7:0] & dmask;
        rx_ent.pe   = pen && (rx_al[nbits] != par_of(rx_ent.data, lcr_q[`UCB_LCR_EPS]));
        rx_ent.fe   = !rx_s_q;
        rx_ent.brk  = !rx_s_q && rx_ent.data == 8'h0 && !(pen && rx_al[nbits]);
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rx_m_q  <= 1'b1;
            rx_s_q  <= 1'b1;
            rx_p_q  <= 1'b1;
            rx_st_q <= UCB_RX_IDLE;
            rx_os_q <= 5'h0;
            rx_k_q  <= 4'h0;
            rx_sh_q <= 11'h0;
        end else if (CE) begin
            rx_m_q <= RX;
            rx_s_q <= rx_m_q;
            rx_p_q <= rx_s_q;
            case (rx_st_q)
                UCB_RX_IDLE: begin
                    rx_os_q <= 5'h0;
                    if (rx_p_q && !rx_s_q) rx_st_q <= UCB_RX_START;
                end
                UCB_RX_START: begin
                    if (os_tick) begin
                        rx_os_q <= rx_os_q + 5'h1;
                        if (rx_os_q == half_len - 5'h1) begin
                            rx_os_q <= 5'h0;
                            rx_k_q  <= 4'h0;
                            rx_st_q <= rx_s_q ? UCB_RX_IDLE : UCB_RX_BITS;
                        end
                    end
                end
                default: begin
                    if (os_tick) begin
                        rx_os_q <= rx_os_q + 5'h1;
                        if (rx_os_q == bit_len - 5'h1) begin
                            rx_os_q <= 5'h0;
                            rx_sh_q <= rx_full;
                            rx_k_q  <= rx_k_q + 4'h1;
                            if (rx_done) rx_st_q <= UCB_RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Receive fifo with error tags
    ucb_rxent_t          rxm [0:`UCB_DEPTH-1];
    logic [`UCB_PW-1:0]  rwp_q, rrp_q;
    logic [6:0]          rcnt_q;
    logic                rx_push, rx_pop, rx_clr, oe_q;
    ucb_rxent_t          head;

    assign rx_push = rx_done && rcnt_q < cap;
    assign rx_pop  = BUS.rd && BUS.addr == `UCB_A_DATA && !dlab && rcnt_q != 7'h0;
    assign rx_clr  = BUS.wr && BUS.addr == `UCB_A_ISR && BUS.wdata[`UCB_FCR_RXCLR];
    assign head    = rxm[rrp_q];

    always_ff @(posedge CORE_CLK) begin
        if (CE && rx_push) rxm[rwp_q] <= rx_ent;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rwp_q  <= '0;
            rrp_q  <= '0;
            rcnt_q <= 7'h0;
        end else if (CE) begin
            if (rx_clr) begin
                rwp_q  <= '0;
                rrp_q  <= '0;
                rcnt_q <= 7'h0;
            end else begin
                if (rx_push) rwp_q <= rwp_q + 1'b1;
                if (rx_pop) rrp_q <= rrp_q + 1'b1;
                rcnt_q <= rcnt_q + {6'h0, rx_push} - {6'h0, rx_pop};
            end
        end
    end

    // Receive timeout in bit times
    logic [4:0] bt_q;
    logic [7:0] to_cnt_q, to_lim;
    logic       to_hit;

    assign to_lim = {2'h0, nbits, 2'h0} + `UCB_TO_EXTRA;
    assign to_hit = to_cnt_q >= to_lim && rcnt_q != 7'h0;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            bt_q     <= 5'h0;
            to_cnt_q <= 8'h0;
        end else if (CE) begin
            if (os_tick) bt_q <= (bt_q >= bit_len - 5'h1) ? 5'h0 : bt_q + 5'h1;
            if (rx_push || rx_pop || rcnt_q == 7'h0) begin
                to_cnt_q <= 8'h0;
            end else if (os_tick && bt_q >= bit_len - 5'h1 && !to_hit) begin
                to_cnt_q <= to_cnt_q + 8'h1;
            end
        end
    end

    // Trigger levels and hysteresis
    logic [6:0] rx_trig, rx_up, rx_lo, tx_trig;
    always_comb begin
        case (fcr_q[7:6])
            2'h0: begin rx_trig = 7'h01; rx_up = 7'h10; rx_lo = 7'h00; end
            2'h1: begin rx_trig = 7'h10; rx_up = 7'h20; rx_lo = 7'h01; end
            2'h2: begin rx_trig = 7'h20; rx_up = 7'h38; rx_lo = 7'h10; end
            default: begin rx_trig = 7'h38; rx_up = 7'h40; rx_lo = 7'h20; end
        endcase
        case (fcr_q[5:4])
            2'h0:    tx_trig = 7'h08;
            2'h1:    tx_trig = 7'h10;
            2'h2:    tx_trig = 7'h20;
            default: tx_trig = 7'h38;
        endcase
    end

    // Auto RTS and its sticky interrupt
    logic flow_off_q, rts_n_d, rts_int_q, isr_rd, lsr_rd;
    assign rts_n_d = !(mcr_q[`UCB_MCR_RTS] && !flow_off_q);
    assign isr_rd  = BUS.rd && BUS.addr == `UCB_A_ISR;
    assign lsr_rd  = BUS.rd && BUS.addr == `UCB_A_LSR;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            flow_off_q <= 1'b0;
            RTS_N      <= 1'b1;
            rts_int_q  <= 1'b0;
            oe_q       <= 1'b0;
        end else if (CE) begin
            if (!efr_q[`UCB_EFR_ARTS]) flow_off_q <= 1'b0;
            else if (rcnt_q >= rx_up) flow_off_q <= 1'b1;
            else if (rcnt_q <= rx_lo) flow_off_q <= 1'b0;
            RTS_N <= rts_n_d;
            // Set wins over the clearing read
            if (!RTS_N && rts_n_d && ier_q[`UCB_IER_RTS] && efr_q[`UCB_EFR_ENH]) begin
                rts_int_q <= 1'b1;
            end else if (CE && isr_rd) begin
                rts_int_q <= 1'b0;
            end
            if (rx_done && !rx_push) oe_q <= 1'b1;
            else if (lsr_rd) oe_q <= 1'b0;
        end
    end

    // Status, interrupt identification and read port
    logic       rx_int, tx_int, thr_e, tsr_e;
    logic [7:0] line_status_reg, interrupt_status_reg, rmux;
    assign thr_e  = tcnt_q == 7'h0;
    assign tsr_e  = thr_e && !tx_busy_q;
    assign rx_int = ier_q[`UCB_IER_RX]
                    && (fifo_on ? rcnt_q >= rx_trig : rcnt_q != 7'h0);
    assign tx_int = ier_q[`UCB_IER_TX]
                    && (fifo_on ? tcnt_q < tx_trig : thr_e);
    assign line_status_reg    = {1'b0, tsr_e, thr_e,
                     rcnt_q != 7'h0 && head.brk, rcnt_q != 7'h0 && head.fe,
                     rcnt_q != 7'h0 && head.pe, oe_q, rcnt_q != 7'h0};

    always_comb begin
        if (ier_q[`UCB_IER_RX] && to_hit) interrupt_status_reg = `UCB_ISR_TO;
        else if (rx_int) interrupt_status_reg = `UCB_ISR_RX;
        else if (tx_int) interrupt_status_reg = `UCB_ISR_TX;
        else if (rts_int_q) interrupt_status_reg = `UCB_ISR_RTS;
        else interrupt_status_reg = `UCB_ISR_NONE;
        if (BUS.addr == `UCB_A_DATA && dlab) rmux = dll_q;
        else if (BUS.addr == `UCB_A_DATA) rmux = head.data;
        else if (BUS.addr == `UCB_A_IER && dlab) rmux = dlm_q;
        else if (BUS.addr == `UCB_A_IER) rmux = ier_q;
        else if (BUS.addr == `UCB_A_ISR) rmux = interrupt_status_reg;
        else if (BUS.addr == `UCB_A_LCR) rmux = lcr_q;
        else if (BUS.addr == `UCB_A_MCR) rmux = mcr_q;
        else if (BUS.addr == `UCB_A_LSR) rmux = line_status_reg;
        else if (BUS.addr == `UCB_A_ENHANCED_MODE_STATUS_REG) rmux = enhanced_mode_status_reg_q;
        else rmux = efr_q;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            BUS.rdata <= 8'h0;
            BUS.irq   <= 1'b0;
        end else if (CE) begin
            if (BUS.rd) BUS.rdata <= rmux;
            BUS.irq <= interrupt_status_reg != `UCB_ISR_NONE;
        end
    end
endmodule // ucb_dev
`default_nettype wire

// [rtl/ucb_host.sv]
// Host end: APB command registers driving the UART register port
`timescale 1ns/1ps
`default_nettype none
`include "ucb_params.svh"
module ucb_host (
    // Clock, reset, enable
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    output var  logic        IRQ,
    // Register port toward the UART
    ucb_if.host              BUS
);
    import ucb_pkg::*;

    ucb_host_st_t st_q;
    logic [7:0]   rd_q;
    logic         acc, done, map, launch;

    assign acc    = PSEL && PENABLE && !PREADY;
    assign done   = PSEL && PENABLE && PREADY;
    assign map    = PADDR == `UCB_H_CMD || PADDR == `UCB_H_STAT;
    // Commands while busy are dropped; software polls the busy bit
    assign launch = done && PWRITE && PADDR == `UCB_H_CMD && st_q == UCB_H_IDLE;

    // APB answer after one wait state
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= acc;
            PSLVERR <= acc && !map;
            if (acc && !PWRITE && PADDR == `UCB_H_STAT) begin
                PRDATA <= {22'h0, BUS.irq, st_q != UCB_H_IDLE, rd_q};
            end else begin
                PRDATA <= 32'h0;
            end
        end
    end

    // Byte port sequencer; divisor bytes pass as written
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_q      <= UCB_H_IDLE;
            rd_q      <= 8'h0;
            IRQ       <= 1'b0;
            BUS.addr  <= 3'h0;
            BUS.wdata <= 8'h0;
            BUS.wr    <= 1'b0;
            BUS.rd    <= 1'b0;
        end else if (CE) begin
            IRQ <= BUS.irq;
            case (st_q)
                UCB_H_IDLE: begin
                    if (launch) begin
                        BUS.addr  <= PWDATA[10:8];
                        BUS.wdata <= PWDATA[7:0];
                        BUS.wr    <= PWDATA[`UCB_H_WRBIT];
                        BUS.rd    <= !PWDATA[`UCB_H_WRBIT];
                        st_q      <= UCB_H_STROBE;
                    end
                end
                UCB_H_STROBE: begin
                    BUS.wr <= 1'b0;
                    BUS.rd <= 1'b0;
                    st_q   <= BUS.rd ? UCB_H_CAPT : UCB_H_IDLE;
                end
                default: begin
                    rd_q <= BUS.rdata;
                    st_q <= UCB_H_IDLE;
                end
            endcase
        end
    end
endmodule // ucb_host
`default_nettype wire

// [test/ucb_monitor.sv]
// Checker for the register port between the host end and the UART end
`timescale 1ns/1ps
`default_nettype none
`include "ucb_params.svh"
module ucb_monitor (
    // Clock and reset
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] rdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       irq
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_strobe_excl: assert property (!(wr && rd)) else $error("wr and rd together");
    a_wr_pulse: assert property (wr |=> !wr && !rd) else $error("wr longer than one cycle");
    a_rd_pulse: assert property (rd |=> !rd && !wr) else $error("rd longer than one cycle");
    // Read data only moves on a read strobe
    a_rdata_hold: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
    a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !irq && rdata == 8'h00)
        else $error("port not quiet in reset");
    // All-empty can only stand when the holding side is empty too
    a_lsr_tx_order: assert property (rd && addr == `UCB_A_LSR |=> !rdata[6] || rdata[5])
        else $error("tx all empty without holding empty");
    a_lsr_err_ready: assert property (rd && addr == `UCB_A_LSR |=>
        rdata[4:2] == 3'h0 || rdata[0]) else $error("error tags without data");
    a_isr_codes: assert property (rd && addr == `UCB_A_ISR |=>
        rdata inside {8'h01, 8'h02, 8'h04, 8'h0c, 8'h20}) else $error("bad interrupt code");
    c_timeout: cover property (rd && addr == `UCB_A_ISR ##1 rdata == `UCB_ISR_TO);
    c_rts: cover property (rd && addr == `UCB_A_ISR ##1 rdata == `UCB_ISR_RTS);
    c_irq: cover property ($rose(irq));
endmodule // ucb_monitor
`default_nettype wire

// [test/tb.sv]
// Bench joining host end and UART end, serial output looped to input
`timescale 1ns/1ps
`default_nettype none
`include "ucb_params.svh"
module tb;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, r;
    logic        prdy, perr, irq_o, tx_w, rts_n, e;
    int          fail_count = 0;
    int          n_tests = 0;
    int          n, i;
    int          bt[3] = '{16, 32, 128};
    ucb_if bus ();
    always #4 clk = ~clk;
    ucb_host ucb_host_inst (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'h1), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .IRQ(irq_o), .BUS(bus.host));
    ucb_dev ucb_dev_inst (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'h1), .BUS(bus.dev),
        .RX(tx_w), .TX(tx_w), .RTS_N(rts_n));
    ucb_monitor ucb_monitor_inst (.CORE_CLK(clk), .RST_N(rst_n), .addr(bus.addr),
        .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd), .irq(bus.irq));
    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", s, x, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (prdy !== 1'h1);
        r = prd;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    // Commands are dropped while busy, so every command waits here
    task idle;
        do begin
            apb(1'h0, `UCB_H_STAT, 32'h0);
        end while (r[`UCB_H_BUSY] !== 1'h0);
    endtask
    task dwr(input logic [2:0] a, input logic [7:0] d);
        apb(1'h1, `UCB_H_CMD, {20'h0, 1'h1, a, d});
        idle();
    endtask
    task drd(input logic [2:0] a);
        apb(1'h1, `UCB_H_CMD, {20'h0, 1'h0, a, 8'h00});
        idle();
    endtask
    task wait_rx;
        do begin
            drd(`UCB_A_LSR);
        end while (r[0] !== 1'h1);
    endtask
    // Low time of the line from its next falling edge
    task meas;
        int k;
        k = 0;
        n = 0;
        while (tx_w !== 1'h0 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        while (tx_w === 1'h0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task results;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        drd(`UCB_A_LSR);
        chk("lsr", 32'h60, r[7:0]);
        apb(1'h0, 12'h008, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        dwr(`UCB_A_LCR, 8'h80);
        drd(3'h0);
        chk("dll", 32'h01, r[7:0]);
        drd(3'h1);
        chk("dlm", 32'h00, r[7:0]);
        dwr(3'h1, 8'h09);
        drd(3'h1);
        chk("dlm", 32'h09, r[7:0]);
        dwr(3'h1, 8'h00);
        dwr(3'h0, 8'h02);
        dwr(`UCB_A_LCR, 8'h03);
        dwr(`UCB_A_IER, 8'h03);
        $display("test reset done");
        // Divisor two: 8x, 16x, then 16x with prescale four
        for (i = 0; i < 3; i++) begin
            dwr(`UCB_A_ENHANCED_MODE_STATUS_REG, (i > 0) ? 8'h80 : 8'h00);
            dwr(`UCB_A_MCR, (i == 2) ? 8'h80 : 8'h00);
            fork
                dwr(`UCB_A_DATA, 8'ha5);
                meas();
            join
            chk("start bit", bt[i], n);
            drd(`UCB_A_ISR);
            chk("isr", 32'h02, r[7:0]);
            wait_rx();
            drd(`UCB_A_ISR);
            chk("isr", 32'h04, r[7:0]);
            drd(`UCB_A_DATA);
            chk("rx byte", 32'ha5, r[7:0]);
        end
        $display("test rates done");
        dwr(`UCB_A_IER, 8'h01);
        dwr(`UCB_A_FCR, 8'h41);
        dwr(`UCB_A_MCR, 8'h00);
        dwr(`UCB_A_ENHANCED_MODE_STATUS_REG, 8'h00);
        dwr(`UCB_A_DATA, 8'h5a);
        wait_rx();
        drd(`UCB_A_ISR);
        chk("isr", 32'h01, r[7:0]);
        repeat (1200) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq_o});
        drd(`UCB_A_ISR);
        chk("isr", 32'h0c, r[7:0]);
        drd(`UCB_A_DATA);
        chk("rx byte", 32'h5a, r[7:0]);
        $display("test timeout done");
        dwr(`UCB_A_IER, 8'h40);
        dwr(`UCB_A_FCR, 8'h01);
        dwr(`UCB_A_EFR, 8'h50);
        dwr(`UCB_A_MCR, 8'h02);
        chk("rts", 32'h0, {31'h0, rts_n});
        for (i = 0; i < 16; i++) dwr(`UCB_A_DATA, i[7:0]);
        drd(`UCB_A_LSR);
        chk("lsr tx", 32'h0, r[6:5]);
        n = 0;
        while (rts_n !== 1'h1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        drd(`UCB_A_ISR);
        chk("isr", 32'h20, r[7:0]);
        for (i = 0; i < 16; i++) begin
            drd(`UCB_A_DATA);
            chk("rx byte", i, r[7:0]);
        end
        chk("rts", 32'h0, {31'h0, rts_n});
        drd(`UCB_A_LSR);
        chk("lsr", 32'h60, r[7:0]);
        $display("test flow control done");
        results();
    end
endmodule // tb
`default_nettype wire
